// File: pkg/clk_sel_defines.vh
`ifndef CLK_SEL_DEFINES_VH
`define CLK_SEL_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MAX 12'h004
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_SEL 0
`define CTRL_GATE_N 1
`define CTRL_GL 2
`define CTRL_PD_N 3
`define CTRL_FORCE 4
`define CTRL_W 5
`define CTRL_RESET 5'h08
// ----------------------------------------
// Switch timing
// ----------------------------------------
`define PARK_OLD_CYC 3
`define PARK_NEW_CYC 3
`define SW_ST_RUN 2'd0
`define SW_ST_OLD 2'd1
`define SW_ST_NEW 2'd2
`define ZERO32 32'h0000_0000
`endif

// File: design/edge_tap.v
`timescale 1ns/100ps
// Two-stage synchroniser with rising-edge pulse for one source clock
module edge_tap
(
  // System
  input wire hclk,
  input wire hresetn,
  // Sampled line
  input wire line_in,
  // Result
  output reg level,
  output reg rise
);
  reg meta;
  reg sync;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      meta <= line_in;
      sync <= meta;
      level <= sync;
      rise <= sync & ~level;
    end
  end
endmodule // edge_tap

// File: design/glitchless_clock_select_buffer.v
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "clk_sel_defines.vh"
module glitchless_clock_select_buffer
#(
  parameter PARK_OLD = `PARK_OLD_CYC,
  parameter PARK_NEW = `PARK_NEW_CYC
)
(
  // System and AHB-Lite
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Reference clocks
  input wire ref_clk1,
  input wire ref_clk2,
  // Output pairs
  output reg [1:0] clk_out,
  output reg [1:0] clk_out_n
);
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  reg [`CTRL_W-1:0] ctrl;
  reg wr_pend;
  reg [11:0] addr_q;
  reg rd_pend;
  wire take = hsel & hready & htrans[1];
  wire ctrl_wr = wr_pend & (addr_q == `REG_CTRL);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      if (take)
        addr_q <= haddr;
    end
  end
  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  wire lvl1;
  wire lvl2;
  wire rise1;
  wire rise2;
  // Reference 1 sampled into hclk domain
  edge_tap tap1
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in(ref_clk1),
    .level(lvl1),
    .rise(rise1)
  );
  // Reference 2 sampled into hclk domain
  edge_tap tap2
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .line_in(ref_clk2),
    .level(lvl2),
    .rise(rise2)
  );
  // ----------------------------------------
  // Switch state
  // ----------------------------------------
  reg [1:0] state;
  reg cur_sel;
  reg pend_sel;
  reg [1:0] cnt;
  reg run_en;
  reg force_q;
  wire want_sel = ctrl[`CTRL_SEL];
  wire force_rise = ctrl[`CTRL_FORCE] & ~force_q;
  // select 1 follows reference 1, select 0 reference 2
  wire old_rise = cur_sel ? rise1 : rise2;
  wire new_rise = pend_sel ? rise1 : rise2;
  wire cur_lvl = cur_sel ? lvl1 : lvl2;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `CTRL_RESET;
      force_q <= 1'b0;
      state <= `SW_ST_RUN;
      cur_sel <= 1'b0;
      pend_sel <= 1'b0;
      cnt <= 2'd0;
      run_en <= 1'b1;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= hwdata[`CTRL_W-1:0];
      force_q <= ctrl[`CTRL_FORCE];
      if (force_rise)
      begin
        // Dead source gives no edges, so force skips the wait on the old source
        cur_sel <= want_sel;
        pend_sel <= want_sel;
        state <= `SW_ST_NEW;
        run_en <= 1'b0;
        cnt <= 2'd0;
      end
      else
      begin
        case (state)
          `SW_ST_RUN:
          begin
            if (want_sel != cur_sel)
            begin
              pend_sel <= want_sel;
              state <= `SW_ST_OLD;
              cnt <= 2'd0;
            end
          end
          `SW_ST_OLD:
          begin
            // Stop on old low level, or after PARK_OLD - 1 old rises at any level
            if (!cur_lvl)
              run_en <= 1'b0;
            if (old_rise)
              cnt <= cnt + 2'd1;
            if (!cur_lvl || cnt == PARK_OLD - 1)
            begin
              run_en <= 1'b0;
              cur_sel <= pend_sel;
              state <= `SW_ST_NEW;
              cnt <= 2'd0;
            end
          end
          `SW_ST_NEW:
          begin
            if (new_rise)
            begin
              if (cnt == PARK_NEW - 2)
              begin
                run_en <= 1'b1;
                state <= `SW_ST_RUN;
              end
              else
                cnt <= cnt + 2'd1;
            end
          end
          default:
            state <= `SW_ST_RUN;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Gate acts on the very next edge: no wait for a source edge
  wire pd_n = ctrl[`CTRL_PD_N];
  wire gate_n = ctrl[`CTRL_GATE_N];
  wire gl = ctrl[`CTRL_GL];
  wire run_lvl = cur_lvl & run_en;
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : pair
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          clk_out[i] <= 1'b0;
          clk_out_n[i] <= 1'b1;
        end
        else if (!pd_n)
        begin
          clk_out[i] <= 1'b1;
          clk_out_n[i] <= 1'b1;
        end
        else if (gate_n)
        begin
          clk_out[i] <= gl;
          clk_out_n[i] <= ~gl;
        end
        else
        begin
          clk_out[i] <= run_lvl;
          clk_out_n[i] <= ~run_lvl;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= `ZERO32;
    else if (take & ~hwrite)
    begin
      if (haddr == `REG_CTRL)
        hrdata <= {27'h000_0000, ctrl};
      else if (haddr == `REG_STATUS)
        hrdata <= {26'h000_0000, cur_sel, run_en, state, lvl2, lvl1};
      else
        hrdata <= `ZERO32;
    end
  end
endmodule // glitchless_clock_select_buffer

// File: tb/ref_src.sv
`timescale 1ns/100ps
module ref_src
(
  // Control
  input wire stop2,
  // Sources
  output logic ref_clk1 = 0,
  output logic ref_clk2 = 1
);
  // Antiphase, so a wrong pick shows; a stopped source parks high
  initial
  begin
    #3;
    forever
    begin
      #80 ref_clk1 = ~ref_clk1;
      ref_clk2 = stop2 | ~ref_clk1;
    end
  end
endmodule // ref_src

// File: tb/clk_sel_checker.sv
`timescale 1ns/100ps
module clk_sel_checker
#(
  parameter PARK_OLD = 3,
  parameter PARK_NEW = 3
)
(
  // Bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire hready,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  // Clocks
  input wire ref_clk1,
  input wire ref_clk2,
  input wire [1:0] clk_out,
  input wire [1:0] clk_out_n
);
  // Control is not at the ports, so writes are mirrored
  logic [4:0] ctl;
  logic wr_ph;
  logic [6:0] age;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctl <= 5'h08;
      wr_ph <= 0;
      age <= 0;
    end
    else
    begin
      wr_ph <= hsel & hready & htrans[1] & hwrite & (haddr == 0);
      ctl <= wr_ph ? hwdata[4:0] : ctl;
      age <= wr_ph ? 7'h00 : age + (age != 7'h7f);
    end
  wire run = ctl[3] & !ctl[1];
  wire sel_ref = ctl[0] ? ref_clk1 : ref_clk2;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_chg; run && $changed(ctl[0]); endsequence
  sequence s_low; (clk_out == 2'b00) [*8]; endsequence
  property p_fan; clk_out[0] == clk_out[1]; endproperty
  a_fan: assert property (p_fan) else $error("pairs differ");
  property p_comp; clk_out_n == ~clk_out || clk_out_n == 2'b11; endproperty
  a_comp: assert property (p_comp) else $error("bad complement");
  property p_pd; !ctl[3] [*3] |-> clk_out == 3 && clk_out_n == 3; endproperty
  a_pd: assert property (p_pd) else $error("power-down level");
  property p_gate;
    (ctl[3] && ctl[1] && $stable(ctl)) [*3] |-> clk_out == {2{ctl[2]}};
  endproperty
  a_gate: assert property (p_gate) else $error("gated level");
  property p_sel; run && age > 8 && $rose(clk_out[0]) |-> sel_ref; endproperty
  a_sel: assert property (p_sel) else $error("wrong source");
  property p_tog;
    run && age == 7'h7f && $rose(sel_ref) |-> ##[1:8] $rose(clk_out[0]);
  endproperty
  a_tog: assert property (p_tog) else $error("not toggling");
  property p_sw; s_chg |-> ##[1:60] s_low ##[1:70] $rose(clk_out[0]); endproperty
  a_sw: assert property (p_sw) else $error("switch timing");
  property p_frc; $rose(ctl[4]) && run |-> ##[1:80] $rose(clk_out[0]); endproperty
  a_frc: assert property (p_frc) else $error("force failed");
endmodule // clk_sel_checker
bind glitchless_clock_select_buffer clk_sel_checker
  #(.PARK_OLD(PARK_OLD), .PARK_NEW(PARK_NEW)) i_clk_sel_checker
  (.hclk, .hresetn, .hsel, .hready, .haddr, .htrans, .hwrite, .hwdata,
  .ref_clk1, .ref_clk2, .clk_out, .clk_out_n);

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic stop2 = 0;
  logic [1:0] htrans = 0;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic ref_clk1;
  logic ref_clk2;
  logic [1:0] clk_out;
  logic [1:0] clk_out_n;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  ref_src i_ref_src (.stop2, .ref_clk1, .ref_clk2);
  glitchless_clock_select_buffer i_glitchless_clock_select_buffer
    (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ref_clk1, .ref_clk2, .clk_out, .clk_out_n);
  initial
    forever #5 hclk = ~hclk;
  task chk(input string nm, input [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1) @(posedge hclk);
    htrans <= 0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1) @(posedge hclk);
    rd = hrdata;
  endtask
  task toggles;
    logic q;
    n = 0;
    #1 q = clk_out[0];
    repeat (200)
    begin
      #10;
      n += (clk_out[0] !== q);
      q = clk_out[0];
    end
    @(posedge hclk);
  endtask
  task t_regs;
    xfer(1, 12'h010, 0);
    xfer(0, 12'h010, 0);
    chk("unmapped", rd, 0);
    xfer(0, 0, 0);
    chk("ctrl", rd, 5'h08);
    xfer(0, 12'h004, 0);
    chk("status", rd[5:2], 4'h4);
    $display("regs done");
  endtask
  task t_gate;
    for (int g = 0; g < 2; g++)
    begin
      xfer(1, 0, 5'h0a + 4 * g);
      repeat (3) @(posedge hclk);
      #1 chk("q", clk_out, {2{g[0]}});
      chk("qn", clk_out_n, {2{~g[0]}});
    end
    $display("gate done");
  endtask
  task t_pd;
    xfer(1, 0, 5'h02);
    repeat (3) @(posedge hclk);
    #1 chk("q", clk_out, 3);
    chk("qn", clk_out_n, 3);
    xfer(1, 0, 5'h06);
    repeat (3) @(posedge hclk);
    #1 chk("q", clk_out, 3);
    xfer(1, 0, 5'h0e);
    $display("pd done");
  endtask
  task t_sel;
    for (int s = 1; s >= 0; s--)
    begin
      xfer(1, 0, 5'h08 + s);
      toggles;
      chk("toggles", n > 6, 1);
    end
    $display("sel done");
  endtask
  task t_force;
    stop2 <= 1;
    repeat (40) @(posedge hclk);
    xfer(1, 0, 5'h19);
    xfer(1, 0, 5'h09);
    toggles;
    chk("forced", n > 6, 1);
    stop2 <= 0;
    $display("force done");
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    t_regs;
    t_gate;
    t_pd;
    t_sel;
    t_force;
    results;
  end
  // Cuts a hang well past the roughly 700 cycles needed
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results;
    end
  end
endmodule // tb_top
